// [common/oss_pkg.sv]
// constants and types shared by the oscillator source switch
`default_nettype none
package oss_pkg;
  // ****************************************************************
  // register port
  // ****************************************************************
  localparam int unsigned  OSS_ADDR_W       = 4;
  localparam int unsigned  OSS_DATA_W       = 16;
  localparam logic [3:0]   OSS_ADDR_CONTROL = 4'h0;
  localparam logic [3:0]   OSS_ADDR_UNLOCK  = 4'h1;
  // unlock keys, values of our own
  localparam logic [15:0]  OSS_KEY_FIRST    = 16'h5a5a;
  localparam logic [15:0]  OSS_KEY_SECOND   = 16'ha5a5;
  // ****************************************************************
  // oscillator_control field positions, then the permit bit of switch_monitor
  // ****************************************************************
  localparam int unsigned  OSS_CUR_LO   = 12;
  localparam int unsigned  OSS_NEXT_LO  = 8;
  localparam int unsigned  OSS_SEL_LOCK = 7;
  localparam int unsigned  OSS_PIN_LOCK = 6;
  localparam int unsigned  OSS_PLL_LOCK = 5;
  localparam int unsigned  OSS_FAIL     = 3;
  localparam int unsigned  OSS_KEEP     = 2;
  localparam int unsigned  OSS_SEC_EN   = 1;
  localparam int unsigned  OSS_REQ      = 0;
  localparam int unsigned  OSS_PERMIT   = 1;
  // ****************************************************************
  // source and primary mode codes
  // ****************************************************************
  localparam logic [2:0]   OSS_SRC_FRC      = 3'h0;
  localparam logic [2:0]   OSS_SRC_FRC_PLL  = 3'h1;
  localparam logic [2:0]   OSS_SRC_PRI      = 3'h2;
  localparam logic [2:0]   OSS_SRC_PRI_PLL  = 3'h3;
  localparam logic [2:0]   OSS_SRC_SEC      = 3'h4;
  localparam logic [2:0]   OSS_SRC_LOW_POWER_INTERNAL_RC     = 3'h5;
  localparam logic [2:0]   OSS_SRC_RSVD     = 3'h6;
  localparam logic [2:0]   OSS_SRC_FRC_DIV  = 3'h7;
  localparam logic [1:0]   OSS_PM_EXT       = 2'h0;
  localparam logic [1:0]   OSS_PM_STD       = 2'h1;
  localparam logic [1:0]   OSS_PM_HS        = 2'h2;
  localparam logic [1:0]   OSS_PM_OFF       = 2'h3;
  // ****************************************************************
  // reset values and unlock states
  // ****************************************************************
  localparam logic [2:0]   OSS_RST_CURRENT  = OSS_SRC_FRC_DIV;
  localparam logic [1:0]   OSS_RST_UNLOCK   = 2'h0;
  localparam logic [1:0]   OSS_UNLOCK_HALF  = 2'h1;
  localparam logic [1:0]   OSS_UNLOCK_OPEN  = 2'h2;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    OSS_IDLE   = 2'b00,
    OSS_WAIT   = 2'b01,
    OSS_CHANGE = 2'b11,
    OSS_DONE   = 2'b10
  } oss_state_t;
  typedef struct packed {
    logic [1:0] switch_monitor;
    logic [1:0] primary_mode;
    logic [2:0] initial_source;
    logic       output_pin_use;
  } oss_cfg_t;
  typedef struct packed {
    logic pri_ready;
    logic sec_ready;
    logic low_power_internal_rc_ready;
    logic frc_ready;
    logic pll_lock;
    logic fail;
  } oss_status_t;
  localparam int unsigned  OSS_STAT_W = $bits(oss_status_t);
endpackage
`default_nettype wire

// [rtl/oss_sync.sv]
// two-flop synchroniser for the analog oscillator status lines
`default_nettype none
module oss_sync
  import oss_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [OSS_STAT_W-1:0] async_i,
  output logic      [OSS_STAT_W-1:0] sync_o
);
  // ****************************************************************
  // one pair of flops per line
  // ****************************************************************
  logic [OSS_STAT_W-1:0] meta;
  genvar g;
  generate
    for (g = 0; g < OSS_STAT_W; g++) begin : g_bit
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta[g]   <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta[g]   <= async_i[g];
          sync_o[g] <= meta[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [rtl/oss_switch.sv]
// oscillator source selection, switch sequencing and control register
`default_nettype none
// Operation
// - only primary and fast rc use pll
// - fast rc postscaler may divide source
// - instruction clock is oscillator clock over two
// - start-up source from configuration, default 111/11
// - eight-way source code decode
// - primary mode selects crystal flavour
// - software switch requests permitted only when permit bit zero; start-up switch always runs
// - failure monitor active only with 00
// - primary off makes input pin digital
// - output pin carries clock or gpio with primary off or external
// - current source starts divided rc, auto-switches
// - next source loads from initial configuration
// - control writes need unlock sequence first
// - selection lock bit is sticky and read back, blocks no switch
// - pin select lock only gates pin select
// - pll lock flag set, cleared, masked
// - clock fail flag readable, clearable, switch-cleared
// - keep bit holds primary running in sleep
// - secondary enable bit runs secondary oscillator
// - switch request cleared after switch or fallback
// - current field 14:12, next field 10:8
module oss_switch
  import oss_pkg::*;
(
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  RST_I,
  input  wire logic [OSS_ADDR_W-1:0] ADDR_I,
  input  wire logic [OSS_DATA_W-1:0] WDATA_I,
  input  wire logic                  WR_I,
  input  wire logic                  RD_I,
  output logic      [OSS_DATA_W-1:0] RDATA_O,
  input  wire oss_cfg_t              CONFIG_I,
  input  wire logic [OSS_STAT_W-1:0] OSC_STATUS_I,
  input  wire logic                  SLEEP_I,
  output logic      [2:0]            ACTIVE_SOURCE_O,
  output logic                       PLL_EN_O,
  output logic                       FRC_DIV_EN_O,
  output logic                       INSTR_CLK_EN_O,
  output logic                       PRI_OSC_EN_O,
  output logic                       PRI_HIGH_GAIN_O,
  output logic                       PRI_FEEDBACK_EN_O,
  output logic                       SEC_OSC_EN_O,
  output logic                       PRI_IN_DIGITAL_O,
  output logic                       PRI_OUT_CLOCK_O,
  output logic                       PRI_OUT_GPIO_O,
  output logic                       PIN_SELECT_LOCK_O,
  output logic                       SWITCH_BUSY_O
);
  default clocking ast_cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic uses_pll(input logic [2:0] src);
    uses_pll = (src == OSS_SRC_FRC_PLL) || (src == OSS_SRC_PRI_PLL);
  endfunction

  function automatic logic src_ready(input logic [2:0]  src,
                                     input oss_status_t st);
    case (src)
      OSS_SRC_FRC, OSS_SRC_FRC_DIV: src_ready = st.frc_ready;
      OSS_SRC_FRC_PLL: src_ready = st.frc_ready & st.pll_lock;
      OSS_SRC_PRI:     src_ready = st.pri_ready;
      OSS_SRC_PRI_PLL: src_ready = st.pri_ready & st.pll_lock;
      OSS_SRC_SEC:     src_ready = st.sec_ready;
      OSS_SRC_LOW_POWER_INTERNAL_RC:    src_ready = st.low_power_internal_rc_ready;
      default:         src_ready = 1'b0;
    endcase
  endfunction

  // ****************************************************************
  // status synchroniser
  // ****************************************************************
  logic [OSS_STAT_W-1:0] status_sync;
  oss_status_t           st;

  oss_sync u_sync (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .async_i (OSC_STATUS_I),
    .sync_o  (status_sync)
  );
  assign st = oss_status_t'(status_sync);

  // ****************************************************************
  // state
  // ****************************************************************
  oss_cfg_t   cfg;
  oss_state_t state,        next_state;
  logic [2:0] cur_src,      next_cur_src;
  logic [2:0] nxt_src,      next_nxt_src;
  logic [2:0] target,       next_target;
  logic       auto_pending, next_auto_pending;
  logic       sel_lock,     next_sel_lock;
  logic       pin_lock,     next_pin_lock;
  logic       pll_flag,     next_pll_flag;
  logic       fail_flag,    next_fail_flag;
  logic       keep_bit,     next_keep_bit;
  logic       sec_bit,      next_sec_bit;
  logic       req_bit,      next_req_bit;
  logic [1:0] unlock,       next_unlock;
  logic       fail_q;
  logic       instr_phase;

  logic       ctl_wr;
  logic       ctl_ok;
  logic       permit;
  logic       monitor_on;
  logic       fail_evt;
  logic       start;
  logic [2:0] start_src;
  logic [15:0] ctl_word;

  always_comb begin
    ctl_wr     = WR_I && (ADDR_I == OSS_ADDR_CONTROL);
    ctl_ok     = ctl_wr && (unlock == OSS_UNLOCK_OPEN);
    permit     = ~cfg.switch_monitor[OSS_PERMIT];
    monitor_on = (cfg.switch_monitor == 2'h0);
    fail_evt   = monitor_on && st.fail && !fail_q;
    start      = (state == OSS_IDLE) && (auto_pending || (req_bit && permit));
    start_src  = auto_pending ? cfg.initial_source : nxt_src;
    ctl_word   = 16'h0;
    ctl_word[OSS_CUR_LO +: 3]  = cur_src;
    ctl_word[OSS_NEXT_LO +: 3] = nxt_src;
    ctl_word[OSS_SEL_LOCK]     = sel_lock;
    ctl_word[OSS_PIN_LOCK]     = pin_lock;
    ctl_word[OSS_PLL_LOCK]     = pll_flag & uses_pll(cur_src);
    ctl_word[OSS_FAIL]         = fail_flag;
    ctl_word[OSS_KEEP]         = keep_bit;
    ctl_word[OSS_SEC_EN]       = sec_bit;
    ctl_word[OSS_REQ]          = req_bit;
  end

  // ****************************************************************
  // unlock sequence and control register
  // ****************************************************************
  always_comb begin
    next_unlock = unlock;
    if (WR_I) begin
      if (ADDR_I == OSS_ADDR_UNLOCK) begin
        if (WDATA_I == OSS_KEY_FIRST)
          next_unlock = OSS_UNLOCK_HALF;
        else if (unlock == OSS_UNLOCK_HALF && WDATA_I == OSS_KEY_SECOND)
          next_unlock = OSS_UNLOCK_OPEN;
        else
          next_unlock = OSS_RST_UNLOCK;
      end else begin
        // one control write per unlock, any other write re-arms
        next_unlock = OSS_RST_UNLOCK;
      end
    end
  end

  always_comb begin
    next_state        = state;
    next_cur_src      = cur_src;
    next_nxt_src      = nxt_src;
    next_target       = target;
    next_auto_pending = auto_pending;
    next_sel_lock     = sel_lock;
    next_pin_lock     = pin_lock;
    next_pll_flag     = pll_flag;
    next_fail_flag    = fail_flag;
    next_keep_bit     = keep_bit;
    next_sec_bit      = sec_bit;
    next_req_bit      = req_bit;
    // software side first, hardware events below override
    if (ctl_ok) begin
      next_nxt_src  = WDATA_I[OSS_NEXT_LO +: 3];
      next_sel_lock = sel_lock | WDATA_I[OSS_SEL_LOCK];
      next_pin_lock = WDATA_I[OSS_PIN_LOCK];
      next_keep_bit = WDATA_I[OSS_KEEP];
      next_sec_bit  = WDATA_I[OSS_SEC_EN];
      if (!WDATA_I[OSS_FAIL])
        next_fail_flag = 1'b0;
    end
    if (st.pll_lock && uses_pll(cur_src))
      next_pll_flag = 1'b1;
    if (fail_evt) begin
      // fast rc is always there, so fallback needs no wait
      next_cur_src      = OSS_SRC_FRC;
      next_fail_flag    = 1'b1;
      next_req_bit      = 1'b0;
      next_auto_pending = 1'b0;
      next_pll_flag     = 1'b0;
      next_state        = OSS_IDLE;
    end else begin
      case (state)
        OSS_IDLE: begin
          if (start) begin
            if (start_src == cur_src || start_src == OSS_SRC_RSVD) begin
              next_req_bit      = 1'b0;
              next_auto_pending = 1'b0;
            end else begin
              next_target    = start_src;
              next_pll_flag  = 1'b0;
              next_fail_flag = 1'b0;
              next_state     = OSS_WAIT;
            end
          end
        end
        OSS_WAIT: begin
          // old source keeps running meanwhile
          if (src_ready(target, st))
            next_state = OSS_CHANGE;
        end
        OSS_CHANGE: begin
          next_cur_src = target;
          next_state   = OSS_DONE;
        end
        OSS_DONE: begin
          next_req_bit      = 1'b0;
          next_auto_pending = 1'b0;
          next_state        = OSS_IDLE;
        end
        default: next_state = OSS_IDLE;
      endcase
    end
    // a fresh request in the clearing cycle is kept
    if (ctl_ok && WDATA_I[OSS_REQ])
      next_req_bit = 1'b1;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      // fuses are sampled while reset is held
      cfg          <= CONFIG_I;
      state        <= OSS_IDLE;
      cur_src      <= OSS_RST_CURRENT;
      nxt_src      <= CONFIG_I.initial_source;
      target       <= OSS_RST_CURRENT;
      auto_pending <= 1'b1;
      sel_lock     <= 1'b0;
      pin_lock     <= 1'b0;
      pll_flag     <= 1'b0;
      fail_flag    <= 1'b0;
      keep_bit     <= 1'b0;
      sec_bit      <= 1'b0;
      req_bit      <= 1'b0;
      unlock       <= OSS_RST_UNLOCK;
      fail_q       <= 1'b0;
    end else begin
      state        <= next_state;
      cur_src      <= next_cur_src;
      nxt_src      <= next_nxt_src;
      target       <= next_target;
      auto_pending <= next_auto_pending;
      sel_lock     <= next_sel_lock;
      pin_lock     <= next_pin_lock;
      pll_flag     <= next_pll_flag;
      fail_flag    <= next_fail_flag;
      keep_bit     <= next_keep_bit;
      sec_bit      <= next_sec_bit;
      req_bit      <= next_req_bit;
      unlock       <= next_unlock;
      fail_q       <= st.fail;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  logic [15:0] next_rdata;
  logic        next_pll_en;
  logic        next_pri_en;
  logic        pri_used;
  logic        pin_share;

  always_comb begin
    next_rdata = 16'h0;
    if (RD_I && ADDR_I == OSS_ADDR_CONTROL)
      next_rdata = ctl_word;
    else if (RD_I && ADDR_I == OSS_ADDR_UNLOCK)
      next_rdata = {14'h0, unlock};
    // pll only for fast rc and primary branches
    next_pll_en = uses_pll(cur_src) ||
                  (state != OSS_IDLE && uses_pll(target));
    pri_used    = (cur_src == OSS_SRC_PRI) || (cur_src == OSS_SRC_PRI_PLL) ||
                  (state != OSS_IDLE &&
                   (target == OSS_SRC_PRI || target == OSS_SRC_PRI_PLL));
    next_pri_en = pri_used && (!SLEEP_I || keep_bit);
    pin_share   = (cfg.primary_mode == OSS_PM_OFF) ||
                  (cfg.primary_mode == OSS_PM_EXT);
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      RDATA_O           <= 16'h0;
      ACTIVE_SOURCE_O   <= OSS_RST_CURRENT;
      PLL_EN_O          <= 1'b0;
      FRC_DIV_EN_O      <= 1'b0;
      instr_phase       <= 1'b0;
      INSTR_CLK_EN_O    <= 1'b0;
      PRI_OSC_EN_O      <= 1'b0;
      PRI_HIGH_GAIN_O   <= 1'b0;
      PRI_FEEDBACK_EN_O <= 1'b0;
      SEC_OSC_EN_O      <= 1'b0;
      PRI_IN_DIGITAL_O  <= 1'b0;
      PRI_OUT_CLOCK_O   <= 1'b0;
      PRI_OUT_GPIO_O    <= 1'b0;
      PIN_SELECT_LOCK_O <= 1'b0;
      SWITCH_BUSY_O     <= 1'b0;
    end else begin
      RDATA_O           <= next_rdata;
      ACTIVE_SOURCE_O   <= cur_src;
      PLL_EN_O          <= next_pll_en;
      FRC_DIV_EN_O      <= (cur_src == OSS_SRC_FRC_DIV) ||
                           (cur_src == OSS_SRC_FRC_PLL);
      instr_phase       <= ~instr_phase;
      INSTR_CLK_EN_O    <= instr_phase;
      PRI_OSC_EN_O      <= next_pri_en;
      PRI_HIGH_GAIN_O   <= (cfg.primary_mode == OSS_PM_HS);
      PRI_FEEDBACK_EN_O <= (cfg.primary_mode == OSS_PM_HS) ||
                           (cfg.primary_mode == OSS_PM_STD);
      SEC_OSC_EN_O      <= sec_bit || (cur_src == OSS_SRC_SEC);
      PRI_IN_DIGITAL_O  <= (cfg.primary_mode == OSS_PM_OFF);
      PRI_OUT_CLOCK_O   <= pin_share && cfg.output_pin_use;
      PRI_OUT_GPIO_O    <= pin_share && !cfg.output_pin_use;
      PIN_SELECT_LOCK_O <= pin_lock;
      SWITCH_BUSY_O     <= (next_state != OSS_IDLE);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_INSTR_HALF: assert property (
    INSTR_CLK_EN_O |=> !INSTR_CLK_EN_O ##1 INSTR_CLK_EN_O)
    else $error("instruction enable not at half rate");
  AST_PLL_BRANCH: assert property (
    PLL_EN_O |-> $past(uses_pll(cur_src) || uses_pll(target)))
    else $error("pll enabled for a non-pll source");
  AST_RESET_SOURCE: assert property (
    $past(RST_I) |-> cur_src == OSS_SRC_FRC_DIV && auto_pending)
    else $error("current source not divided rc after reset");
  AST_NEXT_LOAD: assert property (
    $past(RST_I) |-> nxt_src == $past(CONFIG_I.initial_source))
    else $error("next source not loaded from configuration");
  AST_LOCKED_WRITE: assert property (ctl_wr &&
    unlock != OSS_UNLOCK_OPEN |=> $stable(nxt_src) && $stable(sec_bit))
    else $error("control write taken without unlock");
  AST_SWITCH_BARRED: assert property (state == OSS_IDLE &&
    !auto_pending && cfg.switch_monitor[OSS_PERMIT] && !fail_evt
    |=> state == OSS_IDLE && $stable(cur_src))
    else $error("switch started while not permitted");
  AST_START_CLEARS: assert property (
    (state == OSS_IDLE && next_state == OSS_WAIT) |=> !pll_flag && !fail_flag)
    else $error("lock or fail flag survived switch start");
  AST_CHANGE_OVER: assert property (state == OSS_WAIT &&
    src_ready(target, st) && !fail_evt |=> state == OSS_CHANGE
    ##1 cur_src == $past(target, 2) ##1 ACTIVE_SOURCE_O == cur_src)
    else $error("change-over did not follow ready source");
  AST_REQ_DONE: assert property (state == OSS_DONE &&
    !(ctl_ok && WDATA_I[OSS_REQ]) |=> !req_bit && state == OSS_IDLE)
    else $error("switch request not cleared at completion");
  AST_FAIL_FALLBACK: assert property (fail_evt |=> !req_bit &&
    fail_flag && cur_src == OSS_SRC_FRC ##1 ACTIVE_SOURCE_O == OSS_SRC_FRC)
    else $error("failure did not fall back to fast rc");
  AST_PIN_DIGITAL: assert property (
    $past(!RST_I) |-> PRI_IN_DIGITAL_O == (cfg.primary_mode == OSS_PM_OFF))
    else $error("primary input pin use wrong");
endmodule
`default_nettype wire

// [tb/tb_oss_switch.sv]
// self-checking bench for the oscillator source switch
`default_nettype none
module tb_oss_switch
  import oss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  SYS_CLK_I = 1'b0;
  logic                  RST_I     = 1'b1;
  logic [OSS_ADDR_W-1:0] ADDR_I    = '0;
  logic [OSS_DATA_W-1:0] WDATA_I   = '0;
  logic                  WR_I      = 1'b0;
  logic                  RD_I      = 1'b0;
  logic                  SLEEP_I   = 1'b0;
  oss_cfg_t              cfg       = '0;
  oss_status_t           st        = '0;
  logic [OSS_DATA_W-1:0] rdata;
  logic [2:0]            active;
  logic                  pll_en, div_en, icyc, pri_en, gain, fb, sec_en;
  logic                  in_dig, out_clk, out_gpio, pin_lock, busy;
  logic [15:0]           d;
  logic                  a;
  int                    failures  = 0;
  int                    n_compared = 0;

  oss_switch DUT (
    .SYS_CLK_I        (SYS_CLK_I),
    .RST_I            (RST_I),
    .ADDR_I           (ADDR_I),
    .WDATA_I          (WDATA_I),
    .WR_I             (WR_I),
    .RD_I             (RD_I),
    .RDATA_O          (rdata),
    .CONFIG_I         (cfg),
    .OSC_STATUS_I     (st),
    .SLEEP_I          (SLEEP_I),
    .ACTIVE_SOURCE_O  (active),
    .PLL_EN_O         (pll_en),
    .FRC_DIV_EN_O     (div_en),
    .INSTR_CLK_EN_O   (icyc),
    .PRI_OSC_EN_O     (pri_en),
    .PRI_HIGH_GAIN_O  (gain),
    .PRI_FEEDBACK_EN_O(fb),
    .SEC_OSC_EN_O     (sec_en),
    .PRI_IN_DIGITAL_O (in_dig),
    .PRI_OUT_CLOCK_O  (out_clk),
    .PRI_OUT_GPIO_O   (out_gpio),
    .PIN_SELECT_LOCK_O(pin_lock),
    .SWITCH_BUSY_O    (busy)
  );

  always #25 SYS_CLK_I = ~SYS_CLK_I;

  // ****************************************************************
  // bus and helper tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] dat);
    @(posedge SYS_CLK_I);
    WR_I    <= 1'b1;
    ADDR_I  <= ad;
    WDATA_I <= dat;
    @(posedge SYS_CLK_I);
    WR_I    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] ad, output logic [15:0] dat);
    @(posedge SYS_CLK_I);
    RD_I   <= 1'b1;
    ADDR_I <= ad;
    @(posedge SYS_CLK_I);
    RD_I   <= 1'b0;
    #1 dat = rdata;
  endtask

  // unlock pair then control write; any write in between cancels it
  task automatic wr_ctl(input logic [15:0] dat);
    wr(OSS_ADDR_UNLOCK, OSS_KEY_FIRST);
    wr(OSS_ADDR_UNLOCK, OSS_KEY_SECOND);
    wr(OSS_ADDR_CONTROL, dat);
  endtask

  // no timeout in the sequencer, so the bench bounds the wait itself
  task automatic wait_idle();
    int n;
    repeat (4) @(posedge SYS_CLK_I);
    for (n = 0; n < 50 && busy !== 1'b0; n++) @(posedge SYS_CLK_I);
    if (busy !== 1'b0) check(16'h0bad, 16'h0000);
  endtask

  task automatic do_reset(input oss_cfg_t c);
    @(posedge SYS_CLK_I);
    cfg   <= c;
    RST_I <= 1'b1;
    repeat (19) @(posedge SYS_CLK_I);
    RST_I <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    st = '{pri_ready:1'b0, sec_ready:1'b1, low_power_internal_rc_ready:1'b0,
           frc_ready:1'b1, pll_lock:1'b1, fail:1'b0};
    do_reset('{switch_monitor:2'h0, primary_mode:OSS_PM_OFF,
               initial_source:OSS_SRC_SEC, output_pin_use:1'b1});
    #1 check({13'h0, active}, 16'h0007);
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h7400);
    check({13'h0, in_dig, out_clk, out_gpio}, 16'h0006);
    wait_idle();
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h4400);
    check({15'h0, sec_en}, 16'h0001);
    $display("test reset and start-up switch done");
    wr(OSS_ADDR_CONTROL, 16'h0001);
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h4400);
    rd(4'h5, d);
    check(d, 16'h0000);
    wr(OSS_ADDR_UNLOCK, OSS_KEY_FIRST);
    rd(OSS_ADDR_UNLOCK, d);
    check(d, 16'h0001);
    $display("test locked and unmapped access done");
    wr_ctl(16'h0001);
    wait_idle();
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h0000);
    wr_ctl(16'h0101);
    wait_idle();
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h1120);
    repeat (2) @(posedge SYS_CLK_I);
    check({14'h0, pll_en, div_en}, 16'h0003);
    check({13'h0, active}, 16'h0001);
    @(posedge SYS_CLK_I);
    #1 a = icyc;
    @(posedge SYS_CLK_I);
    #1 check({15'h0, a ^ icyc}, 16'h0001);
    $display("test software switches done");
    @(posedge SYS_CLK_I);
    st.fail <= 1'b1;
    repeat (6) @(posedge SYS_CLK_I);
    st.fail <= 1'b0;
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h0108);
    wr_ctl(16'h0001);
    repeat (4) @(posedge SYS_CLK_I);
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h0000);
    $display("test failure fallback and redundant switch done");
    do_reset('{switch_monitor:2'h2, primary_mode:OSS_PM_HS,
               initial_source:OSS_SRC_SEC, output_pin_use:1'b0});
    wait_idle();
    wr_ctl(16'h00c1);
    repeat (10) @(posedge SYS_CLK_I);
    rd(OSS_ADDR_CONTROL, d);
    check(d & 16'h70c0, 16'h40c0);
    check({14'h0, gain, fb}, 16'h0003);
    check({13'h0, in_dig, out_clk, pin_lock}, 16'h0001);
    $display("test switch prohibited done");
    // primary not ready until pri_ready is set below, so the start-up switch waits on it
    do_reset('{switch_monitor:2'h1, primary_mode:OSS_PM_STD,
               initial_source:OSS_SRC_PRI, output_pin_use:1'b1});
    repeat (6) @(posedge SYS_CLK_I);
    check({14'h0, busy, pri_en}, 16'h0003);
    check({13'h0, in_dig, out_clk, out_gpio}, 16'h0000);
    check({14'h0, gain, fb}, 16'h0001);
    SLEEP_I <= 1'b1;
    repeat (3) @(posedge SYS_CLK_I);
    check({15'h0, pri_en}, 16'h0000);
    wr_ctl(16'h0206);
    repeat (2) @(posedge SYS_CLK_I);
    check({15'h0, pri_en}, 16'h0001);
    check({15'h0, sec_en}, 16'h0001);
    SLEEP_I      <= 1'b0;
    st.pri_ready <= 1'b1;
    st.fail      <= 1'b1;
    wait_idle();
    rd(OSS_ADDR_CONTROL, d);
    check(d, 16'h2206);
    check({13'h0, active}, 16'h0002);
    $display("test primary sleep and monitor off done");
    give_verdict();
  end

  initial begin
    #400us;
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
